// file: hw/dcw_filter.sv
// dcw_filter: turns an aperture of converter samples into one dc reading
// assumes samples and config synchronous to mclk; config stable during an aperture
`timescale 1ns/1ns
module dcw_filter
    import dcw_pkg::*;
#(
    parameter bit HIGH_ORDER_PRESENT = 1'b1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    // control
    input wire logic start,
    input wire dcw_cfg_t cfg,
    // converter samples
    input wire dcw_sample_t smp,
    // reading out
    output logic rd_valid,
    output logic signed [SAMPLE_W-1:0] rd_value,
    output logic rd_is_zero,
    output logic busy,
    output logic high_z_sel,
    output logic [1:0] mode_used
);

    ////////////////////////////////////////////////////////////////////////
    // weight functions

    // triangular weight: rises to mid aperture, falls to the end
    function automatic logic [WEIGHT_W-1:0] tri_w(input logic [APER_W-1:0] pos,
                                                   input logic [APER_W-1:0] len);
        logic [APER_W-1:0] rev;
        rev = len - pos - 16'h0001;
        tri_w = (pos < rev) ? (pos + 16'h0001) : (rev + 16'h0001);
    endfunction

    // fixed high-order profile, indexed by position scaled into the table
    function automatic logic [WEIGHT_W-1:0] ho_w(input logic [APER_W-1:0] pos,
                                                  input logic [APER_W-1:0] len);
        logic [APER_W+HO_IDX_W-1:0] scaled;
        logic [HO_IDX_W-1:0] idx;
        scaled = {pos, 4'h0} / {4'h0, len};
        idx = scaled[HO_IDX_W-1:0];
        unique case (idx)
            4'h0, 4'hf: ho_w = 16'h0001;
            4'h1, 4'he: ho_w = 16'h0008;
            4'h2, 4'hd: ho_w = 16'h0020;
            4'h3, 4'hc: ho_w = 16'h0058;
            4'h4, 4'hb: ho_w = 16'h00b0;
            4'h5, 4'ha: ho_w = 16'h0110;
            4'h6, 4'h9: ho_w = 16'h0160;
            default: ho_w = 16'h0180;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    dcw_state_t state;
    dcw_mode_t mode;
    logic [APER_W-1:0] len;
    logic [APER_W-1:0] pos;
    logic signed [ACC_W-1:0] acc;
    logic [TOT_W-1:0] tot;
    logic null_en;
    logic null_cap;
    logic signed [SAMPLE_W-1:0] null_off;
    logic signed [SAMPLE_W-1:0] avg;
    logic [WEIGHT_W-1:0] next_w;
    dcw_mode_t next_mode;

    // R3 three-way mode select
    // R7 high-order withheld on reduced variant
    always_comb begin
        unique case (cfg.mode)
            DCW_EQUAL: next_mode = DCW_EQUAL;
            DCW_SECOND: next_mode = DCW_SECOND;
            DCW_HIGH: next_mode = HIGH_ORDER_PRESENT ? DCW_HIGH : DCW_EQUAL;
            default: next_mode = DCW_EQUAL;
        endcase
    end

    always_comb begin
        unique case (mode)
            // R4 equal weights
            DCW_EQUAL: next_w = 16'h0001;
            // R5 triangular weights
            DCW_SECOND: next_w = tri_w(pos, len);
            // R9 fixed coefficient table
            DCW_HIGH: next_w = ho_w(pos, len);
            default: next_w = 16'h0001;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // aperture sequencing and accumulation

    // R2 weighted sum over the aperture
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= DCW_IDLE;
            mode <= DCW_EQUAL;
            len <= APER_MIN;
            pos <= '0;
            acc <= '0;
            tot <= '0;
            null_en <= 1'b0;
            null_cap <= 1'b0;
        end else if (ce) begin
            unique case (state)
                DCW_IDLE: begin
                    if (start) begin
                        state <= DCW_ACCUM;
                        mode <= next_mode;
                        len <= (cfg.aperture < APER_MIN) ? APER_MIN : cfg.aperture;
                        pos <= '0;
                        acc <= '0;
                        tot <= '0;
                        null_en <= cfg.null_en;
                        null_cap <= cfg.null_en & cfg.null_capture;
                    end
                end
                DCW_ACCUM: begin
                    if (smp.valid) begin
                        // widen both factors first so the product is never cut to 24 bits
                        acc <= acc + ACC_W'($signed(smp.value))
                            * ACC_W'($signed({1'b0, next_w}));
                        tot <= tot + TOT_W'(next_w);
                        pos <= pos + 16'h0001;
                        if (pos == len - 16'h0001) begin
                            state <= DCW_DIVIDE;
                        end
                    end
                end
                DCW_DIVIDE: state <= DCW_EMIT;
                DCW_EMIT: state <= DCW_IDLE;
            endcase
        end
    end

    // R9 normalise by total weight
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            avg <= '0;
        end else if (ce && state == DCW_DIVIDE) begin
            avg <= SAMPLE_W'(acc / $signed({1'b0, tot}));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // offset nulling and reading output

    // R1 capture zero reading, subtract later
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            null_off <= '0;
            rd_valid <= 1'b0;
            rd_value <= '0;
            rd_is_zero <= 1'b0;
        end else if (ce) begin
            rd_valid <= 1'b0;
            if (state == DCW_EMIT) begin
                rd_valid <= 1'b1;
                rd_is_zero <= null_cap;
                if (null_cap) begin
                    null_off <= avg;
                    rd_value <= avg;
                end else if (null_en) begin
                    rd_value <= avg - null_off;
                end else begin
                    rd_value <= avg;
                end
            end
        end
    end

    // R8 high input resistance only on lowest ranges
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            high_z_sel <= 1'b0;
            busy <= 1'b0;
            mode_used <= 2'h0;
        end else if (ce) begin
            high_z_sel <= cfg.high_z_req && (cfg.range <= RANGE_LOWEST_HIGH_Z);
            busy <= (state != DCW_IDLE) || start;
            mode_used <= mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_null_subtract: assert property (@(posedge mclk) disable iff (!nrst) // R1
        (ce && state == DCW_EMIT && null_en && !null_cap) |=> (rd_value == avg - $past(null_off)))
        else $error("nulled reading not offset by stored zero");

    a_reading_after_accum: assert property (@(posedge mclk) disable iff (!nrst) // R2
        (ce && state == DCW_DIVIDE) |=> ##1 (rd_valid || !$past(ce)))
        else $error("reading not emitted after aperture");

    a_mode_legal: assert property (@(posedge mclk) disable iff (!nrst) // R3
        mode != DCW_BAD)
        else $error("illegal weighting mode");

    a_equal_weight: assert property (@(posedge mclk) disable iff (!nrst) // R4
        (state == DCW_DIVIDE && mode == DCW_EQUAL) |-> tot == TOT_W'(len))
        else $error("equal mode total weight not sample count");

    a_tri_symmetric: assert property (@(posedge mclk) disable iff (!nrst) // R5
        (mode == DCW_SECOND && state == DCW_ACCUM) |->
        next_w == tri_w(len - pos - 16'h0001, len))
        else $error("triangular weight not symmetric");

    a_no_high_order: assert property (@(posedge mclk) disable iff (!nrst) // R7
        !HIGH_ORDER_PRESENT |-> mode != DCW_HIGH)
        else $error("high-order used on reduced variant");

    a_high_z_range: assert property (@(posedge mclk) disable iff (!nrst) // R8
        (high_z_sel && $past(ce)) |-> $past(cfg.range) <= RANGE_LOWEST_HIGH_Z)
        else $error("high input resistance on a high range");

    a_total_weight: assert property (@(posedge mclk) disable iff (!nrst) // R9
        (ce && state == DCW_ACCUM && smp.valid) |=> tot == $past(tot) + TOT_W'($past(next_w)))
        else $error("total weight not tracked");

endmodule

// file: hw/dcw_pkg.sv
// dcw_pkg: constants and types for the dc reading weighted-average filter
// assumes one system clock; sample stream from a converter front end
// Notes on behaviour
// R1: with nulling on, capture one zero reading and subtract it afterwards.
// R2: each reading is a weighted average of many samples in one aperture.
// R3: rejection setting offers exactly three weighting modes.
// R4: equal mode weights every sample the same.
// R5: second-order mode uses triangular weights peaking mid-aperture.
// R6: configuring party programs 2x aperture for second-order, 4x for high-order.
// R7: reduced variant drops high-order; only equal and second-order selectable.
// R8: high input resistance only on three lowest dc voltage ranges; normal default.
// R9: high-order weights from fixed table by position; sum normalised by total weight.
package dcw_pkg;
    localparam int SAMPLE_W = 24;
    localparam int APER_W = 16;
    localparam int WEIGHT_W = 16;
    localparam int ACC_W = 64;
    localparam int TOT_W = 40;
    localparam int HO_TABLE_N = 16;
    localparam int HO_IDX_W = 4;
    localparam logic [APER_W-1:0] APER_MIN = 16'h0002;
    localparam logic [2:0] RANGE_LOWEST_HIGH_Z = 3'h2;

    typedef enum logic [1:0] {
        DCW_EQUAL,
        DCW_SECOND,
        DCW_HIGH,
        DCW_BAD
    } dcw_mode_t;

    typedef enum logic [1:0] {
        DCW_IDLE,
        DCW_ACCUM,
        DCW_DIVIDE,
        DCW_EMIT
    } dcw_state_t;

    typedef struct packed {
        logic [2:0] range;
        logic high_z_req;
        logic null_en;
        logic null_capture;
        dcw_mode_t mode;
        logic [APER_W-1:0] aperture;
    } dcw_cfg_t;

    typedef struct packed {
        logic valid;
        logic signed [SAMPLE_W-1:0] value;
    } dcw_sample_t;
endpackage

// file: sim/dcw_adc_model.sv
// dcw_adc_model: converter front end sending one aperture of samples
// assumes req is seen with start and n is the true sample count
`timescale 1ns/1ns
module dcw_adc_model
    import dcw_pkg::*;
(
    // clock and request
    input wire logic mclk,
    input wire logic req,
    input wire logic [APER_W-1:0] n,
    input wire logic slow,
    // samples out
    output dcw_sample_t smp
);
    initial begin
        int left;
        int v;
        left = 0;
        smp = '0;
        forever begin
            @(posedge mclk);
            if (req) begin
                left = n;
            end
            #1;
            if (left > 0 && (!slow || $urandom_range(3) != 0)) begin
                v = $urandom_range(32'h1fffff) - 32'h100000;
                smp.valid = 1'b1;
                smp.value = SAMPLE_W'(v);
                left--;
            end else begin
                // idle value keeps changing
                smp.valid = 1'b0;
                smp.value = ~smp.value;
            end
        end
    end
endmodule

// file: sim/dcw_filter_tb.sv
// dcw_filter_tb: random apertures checked against a reference average
// assumes dcw_filter and dcw_adc_model, one 100 MHz clock
`timescale 1ns/1ns
module dcw_filter_tb
    import dcw_pkg::*;
;
    logic mclk = 0;
    logic nrst = 0;
    logic ce = 1;
    logic signed [SAMPLE_W-1:0] rd_value_l;
    logic [1:0] mode_used_l;
    longint zero_l = 0;
    logic start = 0;
    logic req = 0;
    logic slow = 0;
    logic [APER_W-1:0] n = '0;
    dcw_cfg_t cfg = '0;
    dcw_sample_t smp;
    logic rd_valid, rd_is_zero, busy, high_z_sel;
    logic signed [SAMPLE_W-1:0] rd_value;
    logic [1:0] mode_used;
    int failures = 0;
    int n_compared = 0;
    longint zero = 0;
    longint q[$];
    longint ho[8] = '{64'h1, 64'h8, 64'h20, 64'h58, 64'hb0, 64'h110, 64'h160, 64'h180};

    initial forever #5 mclk = ~mclk;

    // reduced variant sees the same stimulus
    dcw_filter #(.HIGH_ORDER_PRESENT(1'b0)) u_dut_lite (.mclk(mclk), .nrst(nrst), .ce(ce),
        .start(start), .cfg(cfg), .smp(smp), .rd_valid(), .rd_value(rd_value_l),
        .rd_is_zero(), .busy(), .high_z_sel(), .mode_used(mode_used_l));
    dcw_filter u_dut (.mclk(mclk), .nrst(nrst), .ce(ce), .start(start), .cfg(cfg),
        .smp(smp), .rd_valid(rd_valid), .rd_value(rd_value), .rd_is_zero(rd_is_zero),
        .busy(busy), .high_z_sel(high_z_sel), .mode_used(mode_used));
    dcw_adc_model u_adc (.mclk(mclk), .req(req), .n(n), .slow(slow), .smp(smp));

    always @(posedge mclk) if (smp.valid && busy) q.push_back($signed(smp.value));

    ////////////////////////////////
    task automatic chk_rd(input logic [SAMPLE_W-1:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected reading at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic [1:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected flag at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        if (failures == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    function automatic longint wt(int m, int p, int nn);
        int h;
        h = p * 16 / nn;
        if (h > 7) h = 15 - h;
        case (m)
            1: return (p + 1 < nn - p) ? p + 1 : nn - p;
            2: return ho[h];
            default: return 1;
        endcase
    endfunction

    function automatic longint avg_of(int m);
        longint s, ws, w;
        s = 0;
        ws = 0;
        foreach (q[i]) begin
            w = wt(m, i, q.size());
            s += w * q[i];
            ws += w;
        end
        return s / ws;
    endfunction

    task automatic run(input int m, input int apt, input bit nen, input bit cap);
        longint e, el;
        int k;
        cfg.mode = dcw_mode_t'(m);
        cfg.aperture = APER_W'(apt);
        cfg.null_en = nen;
        cfg.null_capture = cap;
        n = (apt < 2) ? 16'h2 : APER_W'(apt);
        slow = 1'($urandom_range(1));
        start = 1;
        req = 1;
        @(posedge mclk);
        #1;
        start = 0;
        req = 0;
        k = 0;
        while (rd_valid !== 1'b1 && k < 4 * n + 20) begin
            @(posedge mclk);
            #1;
            k++;
        end
        e = avg_of(m);
        el = avg_of(m == 2 ? 0 : m);
        if (nen && cap) begin
            zero = e;
            zero_l = el;
        end else if (nen) begin
            e -= zero;
            el -= zero_l;
        end
        chk_flag(2'(rd_valid), 2'h1);
        chk_flag(2'(busy), 2'h1);
        chk_rd(rd_value, SAMPLE_W'(e));
        chk_rd(rd_value_l, SAMPLE_W'(el));
        chk_flag(2'(rd_is_zero), 2'(nen && cap));
        chk_flag(mode_used, 2'(m == 3 ? 0 : m));
        chk_flag(mode_used_l, 2'(m == 2 || m == 3 ? 0 : m));
        q.delete();
        @(posedge mclk);
        #1;
        chk_flag(2'(busy), 2'h0);
    endtask

    initial begin
        int a;
        void'($urandom(32'hca25b7b7));
        repeat (10) @(posedge mclk);
        #1;
        nrst = 1;
        @(posedge mclk);
        #1;
        chk_flag(2'(high_z_sel), 2'h0);
        for (int r = 0; r < 16; r++) begin
            cfg.range = 3'(r);
            cfg.high_z_req = r[3];
            @(posedge mclk);
            #1;
            chk_flag(2'(high_z_sel), 2'(r[3] && r[2:0] <= 2));
        end
        // frozen enable holds every output
        ce = 0;
        cfg.range = 3'h0;
        start = 1;
        repeat (3) @(posedge mclk);
        #1;
        chk_flag(2'(high_z_sel), 2'h0);
        chk_flag(2'(busy), 2'h0);
        start = 0;
        ce = 1;
        @(posedge mclk);
        #1;
        for (int i = 0; i < 16; i++) run(i % 4, $urandom_range(2, 60), 0, 0);
        a = $urandom_range(3, 20);
        run(0, a, 0, 0);
        run(1, 2 * a, 0, 0);
        run(2, 4 * a, 0, 0);
        run(2, 16, 0, 0);
        run(0, 1, 0, 0);
        run(1, 0, 0, 0);
        run(1, 20, 1, 1);
        run(0, 9, 1, 0);
        run(2, 33, 1, 0);
        run(0, 5, 0, 0);
        report_and_stop();
    end

    // run needs under 2k cycles
    initial begin
        #500000;
        failures++;
        report_and_stop();
    end
endmodule
